// ### logic/debug_ack_pkg.sv
// shared constants and types for the debug link acknowledge and abort block
package debug_ack_pkg;

   // timing counts, in debug clock cycles
   localparam int ACK_LOW_CYCLES  = 16;
   localparam int MIN_GAP_CYCLES  = 32;
   localparam int SYNC_MIN_CYCLES = 128;
   localparam int ABORT_MIN_CYCLES = 4;
   localparam int SPEEDUP_CYCLES  = 1;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // control register fields
   localparam int CTRL_CLKSEL_BIT = 0;
   localparam int CTRL_ACKEN_BIT  = 1;

   // status register fields
   localparam int STAT_PENDING_BIT = 0;
   localparam int STAT_WSF_BIT     = 1;
   localparam int STAT_CPUREQ_BIT  = 2;
   localparam int STAT_ACKEN_BIT   = 3;
   localparam int STAT_STATE_LSB   = 4;

   // reset values
   localparam logic RESET_CLKSEL = 1'b0;
   localparam logic RESET_ACKEN  = 1'b0;

   typedef enum logic [1:0] {
      CMD_OTHER   = 2'b00,
      CMD_CPU     = 2'b01,
      CMD_ACK_EN  = 2'b10,
      CMD_ACK_DIS = 2'b11
   } cmd_class_type;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_EXEC     = 3'b001,
      ST_GAP      = 3'b010,
      ST_ACK_LOW  = 3'b011,
      ST_ACK_HIGH = 3'b100
   } ack_state_type;

   // command from the serial decoder, pulsed at the 16th cycle of its last bit
   typedef struct packed {
      logic          valid;
      cmd_class_type cls;
   } cmd_type;

   // debug pin drive as two signals
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_type;

   // apb request
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } apb_req_type;

endpackage

// ### logic/debug_link_ack_handshake_abort.sv
// acknowledge handshake and abort logic for the single-wire debug link
//
// Overview of operation
// - processor commands report completion by handshake
// - ack is 16 cycles low then speedup high
// - ack starts at least 32 cycles after command end
// - processor executes command, completion triggers ack
// - wait/stop before execution: no ack, pending stays
// - processor command arriving during wait/stop is discarded
// - no nested acks; abort before new command
// - pending ack never times out
// - long low then high aborts with sync
// - short low of four cycles aborts silently
// - next falling edge after abort starts command
// - processor command runs at next instruction boundary
// - pending flag high while command waits
// - wait/stop failure flag set on failed command
// - handshake enabled by command, off after reset
// - only processor commands and enable get acks
`timescale 1ns/1ns

module debug_link_ack_handshake_abort #(
   parameter int ACK_LOW_CYCLES   = debug_ack_pkg::ACK_LOW_CYCLES,
   parameter int MIN_GAP_CYCLES   = debug_ack_pkg::MIN_GAP_CYCLES,
   parameter int SYNC_MIN_CYCLES  = debug_ack_pkg::SYNC_MIN_CYCLES,
   parameter int ABORT_MIN_CYCLES = debug_ack_pkg::ABORT_MIN_CYCLES,
   parameter int SPEEDUP_CYCLES   = debug_ack_pkg::SPEEDUP_CYCLES
) (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // command decoder
   input  wire debug_ack_pkg::cmd_type      cmd,
   output logic                             first_bit,
   output logic                             sync_request,
   output logic                             abort_done,
   // processor side
   output logic                             cpu_req,
   input  wire logic                        cpu_done,
   input  wire logic                        cpu_wait_stop,
   output logic                             debug_clock_source_select,
   // debug pin
   input  wire logic                        debug_pin_in,
   output debug_ack_pkg::pin_drive_type     debug_pin
);

   localparam int CW = 8;

   generate
      if (ACK_LOW_CYCLES < 1 || MIN_GAP_CYCLES < 1 || SPEEDUP_CYCLES < 1
          || ABORT_MIN_CYCLES < 2 || SYNC_MIN_CYCLES <= ABORT_MIN_CYCLES
          || SYNC_MIN_CYCLES > 254 || ACK_LOW_CYCLES > 255
          || MIN_GAP_CYCLES > 255 || SPEEDUP_CYCLES > 255) begin : g_bad_param
         $error("debug_link_ack_handshake_abort: timing parameter out of range");
      end
   endgenerate

   localparam logic [CW-1:0] ACK_LAST   = CW'(ACK_LOW_CYCLES - 1);
   localparam logic [CW-1:0] SPD_LAST   = CW'(SPEEDUP_CYCLES - 1);
   localparam logic [CW-1:0] GAP_MIN    = CW'(MIN_GAP_CYCLES);
   localparam logic [CW-1:0] ABORT_LAST = CW'(ABORT_MIN_CYCLES - 1);
   localparam logic [CW-1:0] SYNC_MIN   = CW'(SYNC_MIN_CYCLES);
   localparam logic [CW-1:0] CNT_MAX    = 8'hff;

   typedef struct packed {
      debug_ack_pkg::ack_state_type state;
      logic [CW-1:0]                gap_cnt;
      logic [CW-1:0]                ack_cnt;
      logic [CW-1:0]                low_cnt;
      logic                         pin_prev;
      logic                         clk_sel;
      logic                         ack_en;
      logic                         ack_wanted;
      logic                         pending;
      logic                         wait_stop_failure_flag;
      logic                         cpu_req;
      logic                         resync;
      logic                         first_bit;
      logic                         sync_pulse;
      logic                         abort_pulse;
      logic                         pin_out;
      logic                         pin_oe;
      logic [31:0]                  rdata;
      logic                         slverr;
   } state_type;

   debug_ack_pkg::apb_req_type apb;
   state_type                  s_reg;
   state_type                  s_next;
   logic                       driving;
   logic                       fall_edge;
   logic                       rise_edge;
   logic                       abort_now;
   logic                       setup_phase;
   logic                       wr_access;
   logic                       addr_ok;

   assign apb.sel    = psel;
   assign apb.enable = penable;
   assign apb.write  = pwrite;
   assign apb.addr   = paddr;
   assign apb.wdata  = pwdata;

   assign driving     = s_reg.pin_oe;
   // the pin is only watched while we are not driving it, so our own ack is not an abort
   assign fall_edge   = !driving && s_reg.pin_prev && !debug_pin_in;
   assign rise_edge   = !driving && !s_reg.pin_prev && debug_pin_in;
   assign setup_phase = apb.sel && !apb.enable;
   assign wr_access   = apb.sel && apb.enable && apb.write;
   assign addr_ok     = (apb.addr == debug_ack_pkg::CTRL_OFFSET)
                        || (apb.addr == debug_ack_pkg::STATUS_OFFSET);

   // abort only counts against an outstanding acknowledge; plain bits never reach here
   assign abort_now = !driving && !debug_pin_in && (s_reg.low_cnt == ABORT_LAST)
                      && s_reg.ack_wanted
                      && (s_reg.state == debug_ack_pkg::ST_EXEC
                          || s_reg.state == debug_ack_pkg::ST_GAP);

   always_comb begin
      s_next             = s_reg;
      s_next.first_bit   = 1'b0;
      s_next.sync_pulse  = 1'b0;
      s_next.abort_pulse = 1'b0;
      s_next.pin_prev    = debug_pin_in;

      // low-time measurement on the shared pin
      if (driving || debug_pin_in) begin
         s_next.low_cnt = '0;
      end else if (s_reg.low_cnt != CNT_MAX) begin
         s_next.low_cnt = s_reg.low_cnt + 8'h01;
      end
      if (rise_edge && s_reg.low_cnt >= SYNC_MIN) begin
         s_next.sync_pulse = 1'b1;
      end

      // time since command end, saturating
      if (cmd.valid) begin
         s_next.gap_cnt = '0;
      end else if (s_reg.gap_cnt != CNT_MAX) begin
         s_next.gap_cnt = s_reg.gap_cnt + 8'h01;
      end

      // apb writes; hardware updates further down take precedence
      if (wr_access && apb.addr == debug_ack_pkg::CTRL_OFFSET) begin
         s_next.clk_sel = apb.wdata[debug_ack_pkg::CTRL_CLKSEL_BIT];
         s_next.ack_en  = apb.wdata[debug_ack_pkg::CTRL_ACKEN_BIT];
      end
      if (wr_access && apb.addr == debug_ack_pkg::STATUS_OFFSET
          && apb.wdata[debug_ack_pkg::STAT_WSF_BIT]) begin
         s_next.wait_stop_failure_flag = 1'b0;
      end

      if (cmd.valid && cmd.cls == debug_ack_pkg::CMD_ACK_EN) begin
         s_next.ack_en = 1'b1;
      end
      if (cmd.valid && cmd.cls == debug_ack_pkg::CMD_ACK_DIS) begin
         s_next.ack_en = 1'b0;
      end

      unique case (s_reg.state)
         debug_ack_pkg::ST_IDLE: begin
            // a flag left by a wait/stop failure does not block: a later success or a status write clears it
            if (cmd.valid && cmd.cls == debug_ack_pkg::CMD_CPU) begin
               if (cpu_wait_stop) begin
                  s_next.pending = 1'b1;
                  s_next.wait_stop_failure_flag     = 1'b1;
               end else begin
                  s_next.pending    = 1'b1;
                  s_next.cpu_req    = 1'b1;
                  s_next.ack_wanted = s_reg.ack_en;
                  s_next.state      = debug_ack_pkg::ST_EXEC;
               end
            end else if (cmd.valid && cmd.cls == debug_ack_pkg::CMD_ACK_EN) begin
               s_next.ack_wanted = 1'b1;
               s_next.state      = debug_ack_pkg::ST_GAP;
            end
         end
         debug_ack_pkg::ST_EXEC: begin
            // no timeout here: only completion or wait/stop leave this state;
            // a command arriving meanwhile is ignored, so acknowledges never nest
            if (cpu_done) begin
               s_next.cpu_req = 1'b0;
               s_next.pending = 1'b0;
               s_next.wait_stop_failure_flag     = 1'b0;
               s_next.state   = (s_reg.ack_wanted && !abort_now) ?
                                debug_ack_pkg::ST_GAP : debug_ack_pkg::ST_IDLE;
            end else if (cpu_wait_stop) begin
               s_next.cpu_req    = 1'b0;
               s_next.wait_stop_failure_flag        = 1'b1;
               s_next.ack_wanted = 1'b0;
               s_next.state      = debug_ack_pkg::ST_IDLE;
            end
         end
         debug_ack_pkg::ST_GAP: begin
            if (s_reg.gap_cnt >= GAP_MIN && !abort_now) begin
               s_next.ack_cnt = '0;
               s_next.pin_oe  = 1'b1;
               s_next.pin_out = 1'b0;
               s_next.state   = debug_ack_pkg::ST_ACK_LOW;
            end
         end
         debug_ack_pkg::ST_ACK_LOW: begin
            if (s_reg.ack_cnt == ACK_LAST) begin
               s_next.ack_cnt = '0;
               s_next.pin_out = 1'b1;
               s_next.state   = debug_ack_pkg::ST_ACK_HIGH;
            end else begin
               s_next.ack_cnt = s_reg.ack_cnt + 8'h01;
            end
         end
         debug_ack_pkg::ST_ACK_HIGH: begin
            if (s_reg.ack_cnt == SPD_LAST) begin
               s_next.pin_oe     = 1'b0;
               s_next.pin_out    = 1'b0;
               s_next.ack_wanted = 1'b0;
               s_next.state      = debug_ack_pkg::ST_IDLE;
            end else begin
               s_next.ack_cnt = s_reg.ack_cnt + 8'h01;
            end
         end
         default: begin
            s_next.state   = debug_ack_pkg::ST_IDLE;
            s_next.pin_oe  = 1'b0;
            s_next.pin_out = 1'b0;
         end
      endcase

      // abort drops the acknowledge; a running processor access still completes
      if (abort_now) begin
         s_next.ack_wanted  = 1'b0;
         s_next.abort_pulse = 1'b1;
         s_next.resync      = 1'b1;
         if (s_reg.state == debug_ack_pkg::ST_GAP) begin
            s_next.state = debug_ack_pkg::ST_IDLE;
         end
      end else if (s_reg.resync && fall_edge) begin
         s_next.resync    = 1'b0;
         s_next.first_bit = 1'b1;
      end

      // register read data is captured in the setup phase so prdata comes from a flop
      s_next.rdata  = '0;
      s_next.slverr = 1'b0;
      if (setup_phase) begin
         s_next.slverr = !addr_ok;
         if (apb.addr == debug_ack_pkg::CTRL_OFFSET) begin
            s_next.rdata[debug_ack_pkg::CTRL_CLKSEL_BIT] = s_reg.clk_sel;
            s_next.rdata[debug_ack_pkg::CTRL_ACKEN_BIT]  = s_reg.ack_en;
         end else if (apb.addr == debug_ack_pkg::STATUS_OFFSET) begin
            s_next.rdata[debug_ack_pkg::STAT_PENDING_BIT] = s_reg.pending;
            s_next.rdata[debug_ack_pkg::STAT_WSF_BIT]     = s_reg.wait_stop_failure_flag;
            s_next.rdata[debug_ack_pkg::STAT_CPUREQ_BIT]  = s_reg.cpu_req;
            s_next.rdata[debug_ack_pkg::STAT_ACKEN_BIT]   = s_reg.ack_en;
            s_next.rdata[debug_ack_pkg::STAT_STATE_LSB +: 3] = s_reg.state;
         end
      end else if (apb.sel) begin
         s_next.rdata  = s_reg.rdata;
         s_next.slverr = s_reg.slverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg            <= '0;
         s_reg.state      <= debug_ack_pkg::ST_IDLE;
         s_reg.pin_prev   <= 1'b1;
         s_reg.clk_sel    <= debug_ack_pkg::RESET_CLKSEL;
         s_reg.ack_en     <= debug_ack_pkg::RESET_ACKEN;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata                    = s_reg.rdata;
   assign pready                    = 1'b1;
   assign pslverr                   = apb.sel && apb.enable && s_reg.slverr;
   assign first_bit                 = s_reg.first_bit;
   assign sync_request              = s_reg.sync_pulse;
   assign abort_done                = s_reg.abort_pulse;
   assign cpu_req                   = s_reg.cpu_req;
   assign debug_clock_source_select = s_reg.clk_sel;
   assign debug_pin.out             = s_reg.pin_out;
   assign debug_pin.oe              = s_reg.pin_oe;

endmodule // debug_link_ack_handshake_abort

// ### bench/debug_ack_assertions.sv
// checker for the debug link acknowledge and abort block
`timescale 1ns/1ns
module debug_ack_checker #(
   parameter int MIN_GAP_CYCLES  = 32,
   parameter int SYNC_MIN_CYCLES = 128
) (
   // clock and reset
   input wire logic                         pclk,
   input wire logic                         presetn,
   // command and processor
   input wire debug_ack_pkg::cmd_type       cmd,
   input wire logic                         cpu_req,
   input wire logic                         cpu_done,
   // pin and pulses
   input wire logic                         debug_pin_in,
   input wire debug_ack_pkg::pin_drive_type debug_pin,
   input wire logic                         abort_done,
   input wire logic                         sync_request,
   input wire logic                         first_bit
);
   logic [15:0] gap_reg;
   logic [15:0] low_reg;
   logic [15:0] run_reg;
   logic [7:0]  oe_reg;
   // run_reg keeps the last low length so a late sync pulse still sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg <= 16'h0;
         low_reg <= 16'h0;
         run_reg <= 16'h0;
         oe_reg  <= 8'h0;
      end else begin
         gap_reg <= cmd.valid ? 16'h0 : gap_reg + 16'h1;
         low_reg <= debug_pin_in ? 16'h0 : low_reg + 16'h1;
         if (debug_pin_in && low_reg != 16'h0) begin
            run_reg <= low_reg;
         end
         oe_reg <= debug_pin.oe ? oe_reg + 8'h1 : 8'h0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ack_gap: assert property ($rose(debug_pin.oe) |-> gap_reg >= MIN_GAP_CYCLES)
      else $error("ack started too early");
   a_ack_shape: assert property (debug_pin.oe |-> debug_pin.out == (oe_reg == 8'h10))
      else $error("ack level wrong");
   a_ack_release: assert property ($fell(debug_pin.oe) |-> oe_reg == 8'h11)
      else $error("ack length wrong");
   a_sync_length: assert property (sync_request |-> run_reg >= SYNC_MIN_CYCLES)
      else $error("sync on short low");
   a_abort_low: assert property (abort_done |-> !$past(debug_pin_in, 2) && !$past(debug_pin_in, 4))
      else $error("abort without low pulse");
   a_abort_quiet: assert property (abort_done |=> !debug_pin.oe [*8])
      else $error("ack after abort");
   a_first_fall: assert property (first_bit |-> !$past(debug_pin_in))
      else $error("first bit without falling edge");
   a_req_cause: assert property ($rose(cpu_req) |-> $past(cmd.valid) && $past(cmd.cls) == debug_ack_pkg::CMD_CPU)
      else $error("processor request without command");
   a_req_end: assert property (cpu_req && cpu_done |=> !cpu_req)
      else $error("request held after done");
   c_ack: cover property ($rose(debug_pin.oe));
   c_abort: cover property (abort_done);
   c_sync: cover property (sync_request);
endmodule // debug_ack_checker

bind debug_link_ack_handshake_abort debug_ack_checker #(
   .MIN_GAP_CYCLES(MIN_GAP_CYCLES),
   .SYNC_MIN_CYCLES(SYNC_MIN_CYCLES)
) chk (.pclk(pclk), .presetn(presetn), .cmd(cmd), .cpu_req(cpu_req), .cpu_done(cpu_done),
   .debug_pin_in(debug_pin_in), .debug_pin(debug_pin), .abort_done(abort_done),
   .sync_request(sync_request), .first_bit(first_bit));

// ### bench/debug_host_pod.sv
// host pod model: pulled-up wire, abort pulses, ack counting
`timescale 1ns/1ns
module debug_host_pod (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // debug pin
   input  wire debug_ack_pkg::pin_drive_type debug_pin,
   output logic                              debug_pin_in,
   // acks seen
   output int                                acks
);
   logic host_low = 1'b0;
   logic oe_q;
   // pull-up holds the wire high when nobody drives it
   assign debug_pin_in = debug_pin.oe ? debug_pin.out : !host_low;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acks <= 0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= debug_pin.oe;
         if (debug_pin.oe && !oe_q) acks <= acks + 1;
      end
   end
   // low for n cycles, then one released cycle as the speedup
   task automatic drive_low(input int n);
      while (debug_pin.oe) @(posedge pclk);
      host_low <= 1'b1;
      repeat (n) @(posedge pclk);
      host_low <= 1'b0;
      @(posedge pclk);
   endtask
endmodule // debug_host_pod

// ### bench/debug_link_ack_handshake_abort_tb.sv
// testbench for the debug link acknowledge and abort block
`timescale 1ns/1ns
module debug_link_ack_handshake_abort_tb;
   logic                        pclk;
   logic                        presetn;
   logic                        psel;
   logic                        penable;
   logic                        pwrite;
   logic [7:0]                  paddr;
   logic [31:0]                 pwdata;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   debug_ack_pkg::cmd_type      cmd;
   logic                        first_bit;
   logic                        sync_request;
   logic                        abort_done;
   logic                        cpu_req;
   logic                        cpu_done;
   logic                        cpu_wait_stop;
   logic                        clk_sel;
   logic                        debug_pin_in;
   debug_ack_pkg::pin_drive_type debug_pin;
   logic [31:0]                 rd;
   logic                        err;
   int                          acks;
   int                          mismatches = 0;
   int                          compares = 0;
   int                          cycles = 0;
   int                          n_abort = 0;
   int                          n_sync = 0;
   int                          n_first = 0;

   // short sync keeps the run brief
   debug_link_ack_handshake_abort #(.SYNC_MIN_CYCLES(16)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd), .first_bit(first_bit),
      .sync_request(sync_request), .abort_done(abort_done), .cpu_req(cpu_req),
      .cpu_done(cpu_done), .cpu_wait_stop(cpu_wait_stop), .debug_clock_source_select(clk_sel),
      .debug_pin_in(debug_pin_in), .debug_pin(debug_pin));
   debug_host_pod pod (.pclk(pclk), .presetn(presetn), .debug_pin(debug_pin),
      .debug_pin_in(debug_pin_in), .acks(acks));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic wrap_up;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (abort_done === 1'b1) n_abort++;
      if (sync_request === 1'b1) n_sync++;
      if (first_bit === 1'b1) n_first++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic stat(input logic [1:0] exp);
      apb(1'b0, debug_ack_pkg::STATUS_OFFSET, 32'h0);
      chk({30'h0, rd[1:0]}, {30'h0, exp});
   endtask

   task automatic send(input debug_ack_pkg::cmd_class_type c);
      cmd <= '{1'b1, c};
      @(posedge pclk);
      cmd.valid <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic cpu_finish;
      while (cpu_req !== 1'b1) @(posedge pclk);
      cpu_done <= 1'b1;
      @(posedge pclk);
      cpu_done <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, cpu_done, cpu_wait_stop} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      cmd = '{1'b0, debug_ack_pkg::CMD_OTHER};
      waitc(12);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, debug_ack_pkg::CTRL_OFFSET, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, pready}, 32'h1);
      apb(1'b0, debug_ack_pkg::STATUS_OFFSET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, debug_ack_pkg::CTRL_OFFSET, 32'h1);
      chk({31'h0, clk_sel}, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      send(debug_ack_pkg::CMD_CPU);
      cpu_finish();
      waitc(60);
      chk(acks, 0);
      send(debug_ack_pkg::CMD_ACK_EN);
      waitc(60);
      chk(acks, 1);
      send(debug_ack_pkg::CMD_OTHER);
      waitc(60);
      chk(acks, 1);
      // a slow processor: the ack just waits, no timeout
      send(debug_ack_pkg::CMD_CPU);
      waitc(200);
      chk(acks, 1);
      chk({31'h0, cpu_req}, 32'h1);
      stat(2'b01);
      cpu_finish();
      waitc(60);
      chk(acks, 2);
      stat(2'b00);
      send(debug_ack_pkg::CMD_CPU);
      waitc(10);
      // the aborted command still completes on the processor, so a short pulse is safe here
      pod.drive_low(5);
      waitc(4);
      chk(n_abort, 1);
      cpu_finish();
      waitc(60);
      chk(acks, 2);
      pod.drive_low(3);
      waitc(4);
      chk(n_first, 1);
      send(debug_ack_pkg::CMD_CPU);
      waitc(10);
      pod.drive_low(20);
      waitc(4);
      chk(n_sync, 1);
      cpu_finish();
      stat(2'b00);
      waitc(60);
      chk(acks, 2);
      send(debug_ack_pkg::CMD_ACK_DIS);
      send(debug_ack_pkg::CMD_CPU);
      cpu_finish();
      waitc(60);
      chk(acks, 2);
      send(debug_ack_pkg::CMD_ACK_EN);
      waitc(60);
      chk(acks, 3);
      cpu_wait_stop <= 1'b1;
      send(debug_ack_pkg::CMD_CPU);
      waitc(60);
      chk(acks, 3);
      stat(2'b11);
      cpu_wait_stop <= 1'b0;
      apb(1'b1, debug_ack_pkg::STATUS_OFFSET, 32'h2);
      stat(2'b01);
      // a later command that succeeds clears the pending flag left by the failure
      send(debug_ack_pkg::CMD_CPU);
      cpu_finish();
      waitc(60);
      chk(acks, 4);
      stat(2'b00);
      wrap_up();
   end
endmodule // debug_link_ack_handshake_abort_tb
